// [acslr_consts.vh]
// Purpose: constants for the access-control / latency-tolerance register block
// Assumes: byte addresses on a 32-bit APB, one word per register
// Notes:   definitions only
`ifndef ACSLR_CONSTS_VH
`define ACSLR_CONSTS_VH

// register byte offsets
`define ACSLR_OFF_ACS_HDR      12'h220
`define ACSLR_OFF_ACS_CAPCTL   12'h224
`define ACSLR_OFF_EGRESS       12'h228
`define ACSLR_OFF_LTR_HDR      12'h230
`define ACSLR_OFF_LATENCY      12'h234

// capability header fields
`define ACSLR_ACS_CAP_ID       16'h000D
`define ACSLR_LTR_CAP_ID       16'h0018
`define ACSLR_CAP_VERSION      4'h1
`define ACSLR_NEXT_PTR         12'h240

// access-control capability fields
`define ACSLR_CAP_BITS         7'h7F
`define ACSLR_EGRESS_SIZE      8'h08
`define ACSLR_EN_LSB           16
`define ACSLR_EN_MSB           22
`define ACSLR_EN_RESET         7'h00
`define ACSLR_EGRESS_RESET     8'h00

// latency fields
`define ACSLR_SNOOP_VAL_MSB    9
`define ACSLR_SNOOP_SCL_LSB    10
`define ACSLR_SNOOP_SCL_MSB    12
`define ACSLR_NOSNP_VAL_LSB    16
`define ACSLR_NOSNP_VAL_MSB    25
`define ACSLR_NOSNP_SCL_LSB    26
`define ACSLR_NOSNP_SCL_MSB    28
`define ACSLR_LAT_VAL_RESET    10'h000
`define ACSLR_LAT_SCL_RESET    3'h0

`endif

// [acslr_field_reg.v]
// Purpose: one read-write configuration field with byte-lane write strobes
// Assumes: synchronous active-low reset, field sits at bit LSB of the word
// Notes:   bits outside the field are never stored
`timescale 1ns/100ps
`default_nettype none
module acslr_field_reg
#(
    parameter integer WIDTH = 8,
    parameter integer LSB   = 0
)
(
    input  wire              clock,
    input  wire              rstn,
    input  wire              writeEn,
    input  wire [3:0]        byteStrb,
    input  wire [31:0]       writeData,
    output reg  [WIDTH-1:0]  fieldQ
);
    genvar i;
    // each field bit takes its own byte lane strobe
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gBit
            always @(posedge clock)
            begin
                if (!rstn)
                    fieldQ[i] <= 1'b0;
                else if (writeEn && byteStrb[(LSB + i) / 8])
                    fieldQ[i] <= writeData[LSB + i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [acslr_cap_regs.v]
// Purpose: access-control and latency-tolerance capability registers of one port
// Assumes: APB slave, one wait state, port type fixed by an input strap
// Notes:   enables and egress vector leave as registered outputs to routing logic
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "acslr_consts.vh"

// Operation
// - downstream access header reads ID 000Dh, version 1h, next pointer 240h
// - capability bits 0 to 6 read as one, read-only
// - capability bits 15:8 read 08h, the egress vector size
// - bit 16 source validation enable, read-write, reset zero
// - bit 17 translation blocking enable, read-write, reset zero
// - bit 18 request redirect enable, read-write, reset zero
// - bit 19 completion redirect enable, read-write, reset zero
// - bit 20 upstream forwarding enable, read-write, reset zero
// - bit 21 egress control enable, read-write, reset zero
// - bit 22 direct translated enable, read-write, reset zero; 31:23 reserved
// - egress vector bits 7:0 read-write, reset zero, set bit blocks peer port
// - upstream latency header reads ID 0018h, version 1h, next pointer 240h
// - latency bits 9:0 read-write snoop value, reset zero
// - latency bits 12:10 read-write snoop scale, reset zero; 15:13 reserved
// - latency bits 25:16 read-write no-snoop value, reset zero
module acslr_cap_regs
(
    input  wire        clock,
    input  wire        rstn,
    input  wire        isUpstream,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [6:0]  acsEnable,
    output reg  [7:0]  egressBlock,
    output reg  [9:0]  snoopLatValue,
    output reg  [2:0]  snoopLatScale,
    output reg  [9:0]  noSnoopLatValue,
    output reg  [2:0]  noSnoopLatScale
);
    // port type caught by a clocked process after reset release
    reg         upstream_q;
    wire        accessPhase;
    wire        writeAcc;
    wire        hitCapCtl;
    wire        hitEgress;
    wire        hitLatency;
    wire [6:0]  enField;
    wire [7:0]  egrField;
    wire [9:0]  snpVal;
    wire [2:0]  snpScl;
    wire [9:0]  nsnVal;
    wire [2:0]  nsnScl;
    reg  [31:0] readData_d;
    reg         known_d;

    always @(posedge clock)
    begin
        if (!rstn)
            upstream_q <= 1'b0;
        else
            upstream_q <= isUpstream;
    end

    // decode: each set is present only on its own port type
    assign accessPhase = psel && penable;
    assign writeAcc    = accessPhase && pwrite && !pready;
    assign hitCapCtl   = !upstream_q && (paddr == `ACSLR_OFF_ACS_CAPCTL);
    assign hitEgress   = !upstream_q && (paddr == `ACSLR_OFF_EGRESS);
    assign hitLatency  = upstream_q && (paddr == `ACSLR_OFF_LATENCY);

    // access-control enables, bits 22:16
    acslr_field_reg #(.WIDTH(7), .LSB(`ACSLR_EN_LSB)) uEnable
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitCapCtl),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (enField)
    );

    // egress block vector, bits 7:0
    acslr_field_reg #(.WIDTH(8), .LSB(0)) uEgress
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitEgress),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (egrField)
    );

    // snoop latency value and scale
    acslr_field_reg #(.WIDTH(10), .LSB(0)) uSnpVal
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitLatency),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (snpVal)
    );

    acslr_field_reg #(.WIDTH(3), .LSB(`ACSLR_SNOOP_SCL_LSB)) uSnpScl
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitLatency),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (snpScl)
    );

    // no-snoop latency value and scale
    acslr_field_reg #(.WIDTH(10), .LSB(`ACSLR_NOSNP_VAL_LSB)) uNsnVal
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitLatency),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (nsnVal)
    );

    acslr_field_reg #(.WIDTH(3), .LSB(`ACSLR_NOSNP_SCL_LSB)) uNsnScl
    (
        .clock     (clock),
        .rstn      (rstn),
        .writeEn   (writeAcc && hitLatency),
        .byteStrb  (pstrb),
        .writeData (pwdata),
        .fieldQ    (nsnScl)
    );

    // read mux; reserved bits and absent set read zero
    always @*
    begin
        readData_d = 32'h0000_0000;
        known_d    = 1'b1;
        case (paddr)
            `ACSLR_OFF_ACS_HDR:
            begin
                if (!upstream_q)
                    readData_d = {`ACSLR_NEXT_PTR, `ACSLR_CAP_VERSION,
                                  `ACSLR_ACS_CAP_ID};
            end
            `ACSLR_OFF_ACS_CAPCTL:
            begin
                if (!upstream_q)
                    readData_d = {9'h000, enField, `ACSLR_EGRESS_SIZE,
                                  1'b0, `ACSLR_CAP_BITS};
            end
            `ACSLR_OFF_EGRESS:
            begin
                if (!upstream_q)
                    readData_d = {24'h00_0000, egrField};
            end
            `ACSLR_OFF_LTR_HDR:
            begin
                if (upstream_q)
                    readData_d = {`ACSLR_NEXT_PTR, `ACSLR_CAP_VERSION,
                                  `ACSLR_LTR_CAP_ID};
            end
            `ACSLR_OFF_LATENCY:
            begin
                if (upstream_q)
                    readData_d = {3'h0, nsnScl, nsnVal, 3'h0, snpScl, snpVal};
            end
            default:
            begin
                readData_d = 32'h0000_0000;
                known_d    = 1'b0;
            end
        endcase
    end

    // one wait state: answer in the cycle after the first access cycle
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (accessPhase && !pready)
        begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : readData_d;
            pslverr <= !known_d;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // registered copies to routing logic
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            acsEnable       <= `ACSLR_EN_RESET;
            egressBlock     <= `ACSLR_EGRESS_RESET;
            snoopLatValue   <= `ACSLR_LAT_VAL_RESET;
            snoopLatScale   <= `ACSLR_LAT_SCL_RESET;
            noSnoopLatValue <= `ACSLR_LAT_VAL_RESET;
            noSnoopLatScale <= `ACSLR_LAT_SCL_RESET;
        end
        else
        begin
            acsEnable       <= upstream_q ? 7'h00 : enField;
            egressBlock     <= upstream_q ? 8'h00 : egrField;
            snoopLatValue   <= snpVal;
            snoopLatScale   <= snpScl;
            noSnoopLatValue <= nsnVal;
            noSnoopLatScale <= nsnScl;
        end
    end
endmodule
`default_nettype wire

// [acslr_cap_regs_assertions.sv]
// Purpose: port checks for the capability register block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module acslr_cap_regs_assertions
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        isUpstream,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [6:0]  acsEnable,
    input wire logic [7:0]  egressBlock,
    input wire logic [9:0]  snoopLatValue
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic strap_q;
    // port type counts only once settled for two edges
    always @(posedge clock)
        strap_q <= isUpstream;
    wire up = isUpstream && strap_q;
    wire dn = !isUpstream && !strap_q;
    wire rdA = psel && penable && !pready && !pwrite;
    wire wrA = psel && penable && !pready && pwrite;
    property p_acs_hdr; rdA && dn && paddr == 12'h220 |=> prdata == 32'h2401000D; endproperty
    a_acs_hdr: assert property (p_acs_hdr) else $error("access header");
    property p_cap_ro;
        rdA && dn && paddr == 12'h224 |=> prdata[15:0] == 16'h087F && prdata[31:23] == 9'h0;
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("cap bits");
    property p_en_wr;
        wrA && dn && paddr == 12'h224 && pstrb[2] |-> ##2 acsEnable == $past(pwdata[22:16], 2);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enables");
    property p_egress_wr;
        wrA && dn && paddr == 12'h228 && pstrb[0] |-> ##2 egressBlock == $past(pwdata[7:0], 2);
    endproperty
    a_egress_wr: assert property (p_egress_wr) else $error("egress");
    property p_ltr_hdr; rdA && up && paddr == 12'h230 |=> prdata == 32'h24010018; endproperty
    a_ltr_hdr: assert property (p_ltr_hdr) else $error("latency header");
    property p_snoop_wr;
        wrA && up && paddr == 12'h234 && pstrb[0] && pstrb[1]
            |-> ##2 snoopLatValue == $past(pwdata[9:0], 2);
    endproperty
    a_snoop_wr: assert property (p_snoop_wr) else $error("snoop value");
    property p_absent;
        rdA && (dn && paddr[11:4] == 8'h23 || up && paddr[11:4] == 8'h22) |=> prdata == 32'h0;
    endproperty
    a_absent: assert property (p_absent) else $error("absent set");
    property p_up_zero; up && $past(up) |-> acsEnable == 7'h0 && egressBlock == 8'h0; endproperty
    a_up_zero: assert property (p_up_zero) else $error("upstream outputs");
endmodule
bind acslr_cap_regs acslr_cap_regs_assertions u_chk
(
    .clock, .rstn, .isUpstream, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .acsEnable, .egressBlock, .snoopLatValue
);
`default_nettype wire

// [acslr_testbench.sv]
// Purpose: self-checking bench for the capability registers
// Assumes: APB master, one idle cycle after each transfer
// Notes:   table rows first, then output and reset cases
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // row: port type, address, write data, strobes, read value, error
    typedef struct packed {logic [3:0] up; logic [11:0] a; logic [31:0] d;
        logic [3:0] s; logic [31:0] e; logic [3:0] err;} acslr_row_t;
    acslr_row_t  rows [15];
    logic        clock = 1'h0, rstn = 1'h0, isUpstream = 1'h0, er;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0]  pstrb = 4'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [6:0]  acsEnable;
    wire  [7:0]  egressBlock;
    wire  [9:0]  snoopLatValue, noSnoopLatValue;
    wire  [2:0]  snoopLatScale, noSnoopLatScale;
    int          failures = 0, n_compared = 0;
    acslr_cap_regs u_dut
    (
        .clock, .rstn, .isUpstream, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .acsEnable, .egressBlock, .snoopLatValue,
        .snoopLatScale, .noSnoopLatValue, .noSnoopLatScale
    );
    // 25 MHz clock
    initial
        forever #20 clock = ~clock;
    // compare and count
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
            @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    // verdict
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (3000) @(posedge clock);
        failures++;
        stop_test();
    end
    // main sequence
    initial
    begin
        rows = '{88'h0_220_00000000_0_2401000D_0, 88'h0_224_00000000_0_0000087F_0,
            88'h0_228_00000000_0_00000000_0, 88'h0_230_00000000_0_00000000_0,
            88'h0_224_FFFFFFFF_F_007F087F_0, 88'h0_228_FFFFFFA5_F_000000A5_0,
            88'h0_224_00000000_3_007F087F_0, 88'h0_220_00000000_F_2401000D_0,
            88'h0_23C_FFFFFFFF_F_00000000_1, 88'h1_230_00000000_0_24010018_0,
            88'h1_220_00000000_0_00000000_0, 88'h1_234_00000000_0_00000000_0,
            88'h1_234_FFFFFFFF_F_1FFF1FFF_0, 88'h1_234_00000000_4_1F001FFF_0,
            88'h1_224_FFFFFFFF_F_00000000_0};
        repeat (16) @(posedge clock);
        rstn <= 1'h1;
        repeat (2) @(posedge clock);
        foreach (rows[i])
        begin
            if (isUpstream !== rows[i].up[0])
            begin
                isUpstream <= rows[i].up[0];
                repeat (3) @(posedge clock);
            end
            if (rows[i].s !== 4'h0)
            begin
                apb(1'h1, rows[i].a, rows[i].d, rows[i].s);
                chk("write error", {28'h0, rows[i].err}, {31'h0, er});
            end
            apb(1'h0, rows[i].a, 32'h0, 4'h0);
            chk("read data", rows[i].e, rd);
            chk("read error", {28'h0, rows[i].err}, {31'h0, er});
        end
        chk("latency out", 32'h03E01FFF, {6'h0, noSnoopLatScale, noSnoopLatValue,
            snoopLatScale, snoopLatValue});
        isUpstream <= 1'h0;
        repeat (3) @(posedge clock);
        apb(1'h1, 12'h224, 32'h00550000, 4'h4);
        chk("enable out", 32'h55A5, {17'h0, acsEnable, egressBlock});
        rstn <= 1'h0;
        repeat (2) @(posedge clock);
        chk("out in reset", 32'h0, {17'h0, acsEnable, egressBlock});
        rstn <= 1'h1;
        repeat (2) @(posedge clock);
        apb(1'h0, 12'h224, 32'h0, 4'h0);
        chk("cap after reset", 32'h0000087F, rd);
        stop_test();
    end
endmodule
`default_nettype wire
